// ### hw/psi_pkg.sv
// Package for the PCI status and identity register block.
// Assumes AXI4-Lite register access and a separate PCI link clock.
package psi_pkg;
  localparam logic [31:0] ADDR_ID = 32'h80000100;
  localparam logic [31:0] ADDR_SC = 32'h80000104;
  localparam logic [31:0] WIN_LO = 32'h80000100;
  localparam logic [31:0] WIN_HI = 32'h800002FC;
  localparam int B_PERR = 31;
  localparam int B_SERR = 30;
  localparam int B_MABT = 29;
  localparam int B_TABR = 28;
  localparam int B_TABS = 27;
  localparam int B_DPR = 24;
  localparam int B_B2B = 23;
  localparam int B_PRE = 6;
  localparam logic [1:0] SEL_MEDIUM = 2'h1;
  localparam int SEL_LSB = 25;
  localparam int NEV = 6;
  localparam logic [NEV-1:0] EV_ZERO = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO32 = 32'h00000000;

  // Event pulses raised by the PCI core, link-clock domain
  typedef struct packed {
    logic perr_driven;
    logic serr_driven;
    logic master_abort;
    logic target_abort_rx;
    logic target_abort_tx;
    logic init_read_perr;
    logic init_write_perr_seen;
  } psi_link_ev_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } psi_wr_s;
endpackage : psi_pkg

// ### hw/psi_regs.sv
// Identification and status/command registers of the PCI interface.
// Assumes an AXI4-Lite master on mclk_i and a PCI core on pci_clk_i.
`timescale 1ns/1ps
module psi_regs #(
  parameter logic [15:0] PART_ID = 16'h0001, // Arbitrary value
  parameter logic [15:0] MAKER_ID = 16'h0001 // Arbitrary value
) (
  // Clocks and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic pci_clk_i,
  // PCI core events and controls
  input wire psi_pkg::psi_link_ev_s ev_i,
  output logic parity_response_enable_o,
  output logic [1:0] select_timing_code_o,
  // AXI4-Lite write address
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] awaddr_i,
  // AXI4-Lite write data
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // AXI4-Lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // AXI4-Lite read
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [31:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o
);
  import psi_pkg::*;

  typedef struct packed {
    logic [NEV-1:0] tgl;
    logic pre_m1;
    logic pre;
  } psi_link_s;

  typedef struct packed {
    logic [NEV-1:0] s1;
    logic [NEV-1:0] s2;
    logic [NEV-1:0] s3;
    logic [NEV-1:0] stat;
    logic pre;
    logic aw_have;
    logic w_have;
    psi_wr_s wr;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] stc;
  } psi_state_s;

  psi_link_s l_q, l_d;
  psi_state_s s_q, s_d;
  logic [NEV-1:0] ev_raw;
  logic [NEV-1:0] ev_pls;
  logic [31:0] sc_word;

  // Link side: events become toggles so no pulse is lost in crossing
  always_comb begin
    l_d = l_q;
    l_d.pre_m1 = s_q.pre;
    l_d.pre = l_q.pre_m1;
    ev_raw[NEV-1] = ev_i.perr_driven | ev_i.init_read_perr;
    ev_raw[NEV-2] = ev_i.serr_driven;
    ev_raw[NEV-3] = ev_i.master_abort;
    ev_raw[NEV-4] = ev_i.target_abort_rx;
    ev_raw[NEV-5] = ev_i.target_abort_tx;
    ev_raw[0] = l_q.pre &
      (ev_i.init_read_perr | ev_i.init_write_perr_seen);
    l_d.tgl = l_q.tgl ^ ev_raw;
  end

  always_ff @(posedge pci_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Status word as software sees it
  always_comb begin
    sc_word = ZERO32;
    sc_word[B_PERR] = s_q.stat[NEV-1];
    sc_word[B_SERR] = s_q.stat[NEV-2];
    sc_word[B_MABT] = s_q.stat[NEV-3];
    sc_word[B_TABR] = s_q.stat[NEV-4];
    sc_word[B_TABS] = s_q.stat[NEV-5];
    sc_word[B_DPR] = s_q.stat[0];
    sc_word[SEL_LSB+1:SEL_LSB] = SEL_MEDIUM;
    sc_word[B_B2B] = 1'b1;
    // bits 21, 20 and reserved bits stay zero
    sc_word[B_PRE] = s_q.pre;
  end

  always_comb begin
    logic do_wr;
    logic [NEV-1:0] clr;
    logic [NEV-1:0] set;
    do_wr = 1'b0;
    clr = EV_ZERO;
    set = EV_ZERO;
    s_d = s_q;
    // timing code held in a flop
    s_d.stc = SEL_MEDIUM;
    s_d.s1 = l_q.tgl;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    set = s_q.s2 ^ s_q.s3;
    ev_pls = set;
    // Write channel: take address and data in either order
    if (awvalid_i && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.wr.addr = awaddr_i;
      s_d.awready = 1'b0;
    end
    if (wvalid_i && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wr.data = wdata_i;
      s_d.wr.strb = wstrb_i;
      s_d.wready = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      do_wr = 1'b1;
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (s_q.wr.addr == ADDR_SC) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bvalid && bready_i) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end
    if (do_wr && s_q.wr.addr == ADDR_SC) begin
      if (s_q.wr.strb[3]) begin
        clr[NEV-1:1] = {s_q.wr.data[B_PERR:B_TABS]};
        clr[0] = s_q.wr.data[B_DPR];
      end
      if (s_q.wr.strb[0]) begin
        s_d.pre = s_q.wr.data[B_PRE];
      end
    end
    s_d.stat = (s_q.stat & ~clr) | set;
    // Read channel
    if (arvalid_i && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      if (araddr_i == ADDR_ID) begin
        s_d.rdata = {PART_ID, MAKER_ID};
      end else if (araddr_i == ADDR_SC) begin
        s_d.rdata = sc_word;
      end else begin
        s_d.rdata = ZERO32;
        s_d.rresp = RESP_SLVERR;
      end
    end
    if (s_q.rvalid && rready_i) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.stc <= SEL_MEDIUM;
    end else begin
      s_q <= s_d;
    end
  end

  assign parity_response_enable_o = s_q.pre;
  assign select_timing_code_o = s_q.stc;
  assign awready_o = s_q.awready;
  assign wready_o = s_q.wready;
  assign bvalid_o = s_q.bvalid;
  assign bresp_o = s_q.bresp;
  assign arready_o = s_q.arready;
  assign rvalid_o = s_q.rvalid;
  assign rdata_o = s_q.rdata;
  assign rresp_o = s_q.rresp;

  property p_set_wins;
    @(posedge mclk_i) disable iff (!rst_n_i)
      ev_pls[NEV-1] |=> s_q.stat[NEV-1];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("perr lost");

  property p_sticky;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (s_q.stat[NEV-3] && !(awvalid_i || s_q.aw_have)) |=> s_q.stat[NEV-3];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status not sticky");

  property p_sel;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sc_word[SEL_LSB+1:SEL_LSB] == SEL_MEDIUM && sc_word[B_B2B];
  endproperty
  a_sel: assert property (p_sel)
    else $error("fixed bits wrong");

  property p_zero;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sc_word[22:19] == 4'h0 && sc_word[10] == 1'b0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("reserved bit set");

  property p_dpr;
    @(posedge pci_clk_i) disable iff (!rst_n_i)
      !l_q.pre |=> $stable(l_q.tgl[0]);
  endproperty
  a_dpr: assert property (p_dpr)
    else $error("bit 24 without enable");

  property p_perr;
    @(posedge pci_clk_i) disable iff (!rst_n_i)
      ev_i.perr_driven |=> $changed(l_q.tgl[NEV-1]);
  endproperty
  a_perr: assert property (p_perr)
    else $error("perr not seen");

  property p_bad_rd;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (arvalid_i && s_q.arready && araddr_i != ADDR_ID &&
       araddr_i != ADDR_SC) |=> rvalid_o && rresp_o == RESP_SLVERR;
  endproperty
  a_bad_rd: assert property (p_bad_rd)
    else $error("no slverr");

  property p_id;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (arvalid_i && s_q.arready && araddr_i == ADDR_ID) |=>
        rdata_o == {PART_ID, MAKER_ID};
  endproperty
  a_id: assert property (p_id)
    else $error("id word wrong");

  // Write step: both halves held, response not yet raised
  sequence s_wr_ready;
    s_q.aw_have && s_q.w_have && !s_q.bvalid;
  endsequence

  // Write to the status word with the event byte lane on
  sequence s_sc_lane3;
    s_q.wr.addr == ADDR_SC && s_q.wr.strb[3];
  endsequence

  property p_bad_wr;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (s_wr_ready ##0 (s_q.wr.addr != ADDR_SC)) |=>
        bvalid_o && bresp_o == RESP_SLVERR;
  endproperty
  a_bad_wr: assert property (p_bad_wr)
    else $error("bad write not refused");

  // A one clears unless an event lands in the same cycle
  property p_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (s_wr_ready ##0 s_sc_lane3 ##0
       (s_q.wr.data[B_MABT] && !ev_pls[NEV-3])) |=> !s_q.stat[NEV-3];
  endproperty
  a_clear: assert property (p_clear)
    else $error("write one did not clear");

  property p_keep;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (s_wr_ready ##0 s_sc_lane3 ##0
       (!s_q.wr.data[B_MABT] && s_q.stat[NEV-3])) |=> s_q.stat[NEV-3];
  endproperty
  a_keep: assert property (p_keep)
    else $error("write zero cleared a bit");

  property p_pre_wr;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (s_wr_ready ##0 (s_q.wr.addr == ADDR_SC && s_q.wr.strb[0])) |=>
        parity_response_enable_o == $past(s_q.wr.data[B_PRE]);
  endproperty
  a_pre_wr: assert property (p_pre_wr)
    else $error("parity enable not written");

  property p_rst_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> s_q.stat == EV_ZERO;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("status not clear after reset");

  property p_stc;
    @(posedge mclk_i) disable iff (!rst_n_i)
      select_timing_code_o == SEL_MEDIUM;
  endproperty
  a_stc: assert property (p_stc)
    else $error("timing code wrong");

  // Enabled response must record initiator parity errors
  property p_dpr_on;
    @(posedge pci_clk_i) disable iff (!rst_n_i)
      (l_q.pre && ev_i.init_write_perr_seen) |=> $changed(l_q.tgl[0]);
  endproperty
  a_dpr_on: assert property (p_dpr_on)
    else $error("bit 24 event lost");

  // Every event bit: a synchronised pulse always lands
  for (genvar gi = 0; gi < NEV; gi++) begin : g_set
    property p_set_bit;
      @(posedge mclk_i) disable iff (!rst_n_i)
        ev_pls[gi] |=> s_q.stat[gi];
    endproperty
    a_set_bit: assert property (p_set_bit)
      else $error("event bit lost");
  end
endmodule : psi_regs

// ### tb/psi_pci_agent.sv
// PCI agent model: raises single-cycle bus event pulses.
// Assumes a free-running link clock from the bench.
`timescale 1ns/1ps
module psi_pci_agent (
  // Link side
  input wire logic pci_clk_i,
  output psi_pkg::psi_link_ev_s ev_o
);
  import psi_pkg::*;
  initial ev_o = '0;
  // One event per call; k=0 is the top struct field
  task automatic fire(input int k);
    @(posedge pci_clk_i);
    ev_o <= psi_link_ev_s'(7'h40 >> k);
    @(posedge pci_clk_i);
    ev_o <= '0;
  endtask : fire
endmodule : psi_pci_agent

// ### tb/psi_regs_bench.sv
// Bench for the PCI status and identity registers.
// Assumes psi_regs, the PCI agent model and an AXI4-Lite master here.
`timescale 1ns/1ps
module psi_regs_bench;
  import psi_pkg::*;
  localparam logic [31:0] ID = 32'h00010001;
  localparam logic [31:0] SC0 = 32'h02800000;
  logic mclk_i = 1'h0;
  logic pci_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic awvalid_i = 1'h0;
  logic wvalid_i = 1'h0;
  logic bready_i = 1'h0;
  logic arvalid_i = 1'h0;
  logic rready_i = 1'h0;
  logic [31:0] awaddr_i = 32'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] araddr_i = 32'h0;
  logic [3:0] wstrb_i = 4'h0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, pre_o;
  logic [1:0] bresp_o, rresp_o, stc_o;
  logic [31:0] rdata_o;
  psi_link_ev_s ev;
  int num_errors = 0;
  int checked = 0;
  initial forever #25 mclk_i = ~mclk_i;
  initial begin
    #3.7;
    forever #7.5 pci_clk_i = ~pci_clk_i;
  end
  psi_pci_agent agent (.pci_clk_i(pci_clk_i), .ev_o(ev));
  psi_regs dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .pci_clk_i(pci_clk_i),
    .ev_i(ev), .parity_response_enable_o(pre_o),
    .select_timing_code_o(stc_o), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .awaddr_i(awaddr_i), .wvalid_i(wvalid_i),
    .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
    .arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i),
    .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o),
    .rresp_o(rresp_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Edge first, so strobes never change twice in one step
  task automatic wrx(input logic [31:0] a, d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk_i);
    awvalid_i <= 1'h1;
    awaddr_i <= a;
    wvalid_i <= 1'h1;
    wdata_i <= d;
    wstrb_i <= 4'hF;
    bready_i <= 1'h1;
    do begin
      @(posedge mclk_i);
      n++;
      if (awready_o === 1'h1) awvalid_i <= 1'h0;
      if (wready_o === 1'h1) wvalid_i <= 1'h0;
    end while (bvalid_o !== 1'h1 && n < 50);
    if (n >= 50) num_errors++;
    bready_i <= 1'h0;
    chk(32'(bresp_o), 32'(er));
  endtask : wrx
  task automatic rdx(input logic [31:0] a, ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk_i);
    arvalid_i <= 1'h1;
    araddr_i <= a;
    rready_i <= 1'h1;
    do begin
      @(posedge mclk_i);
      n++;
      if (arready_o === 1'h1) arvalid_i <= 1'h0;
    end while (rvalid_o !== 1'h1 && n < 50);
    if (n >= 50) num_errors++;
    rready_i <= 1'h0;
    chk(rdata_o, ed);
    chk(32'(rresp_o), 32'(er));
  endtask : rdx
  task automatic t_reset;
    rdx(ADDR_ID, ID, RESP_OKAY);
    rdx(ADDR_SC, SC0, RESP_OKAY);
    chk(32'(stc_o), 32'(SEL_MEDIUM));
    $display("t_reset done");
  endtask : t_reset
  task automatic t_access;
    wrx(ADDR_ID, 32'hFFFFFFFF, RESP_SLVERR);
    rdx(ADDR_ID, ID, RESP_OKAY);
    rdx(32'h80000108, 32'h0, RESP_SLVERR);
    wrx(WIN_HI, 32'hFFFFFFFF, RESP_SLVERR);
    rdx(ADDR_SC, SC0, RESP_OKAY);
    $display("t_access done");
  endtask : t_access
  // Fire, settle across domains, read, clear
  task automatic ev_rt(input int k, input logic [31:0] on, base);
    agent.fire(k);
    repeat (10) @(posedge mclk_i);
    rdx(ADDR_SC, base | on, RESP_OKAY);
    wrx(ADDR_SC, base & 32'h40, RESP_OKAY);
    rdx(ADDR_SC, base | on, RESP_OKAY);
    wrx(ADDR_SC, on | (base & 32'h40), RESP_OKAY);
    rdx(ADDR_SC, base, RESP_OKAY);
  endtask : ev_rt
  task automatic t_events;
    for (int k = 0; k < 5; k++) begin
      ev_rt(k, 32'h80000000 >> k, SC0);
    end
    $display("t_events done");
  endtask : t_events
  task automatic t_parity;
    ev_rt(5, 32'h80000000, SC0);
    wrx(ADDR_SC, 32'h40, RESP_OKAY);
    chk(32'(pre_o), 32'h1);
    ev_rt(5, 32'h81000000, SC0 | 32'h40);
    ev_rt(6, 32'h01000000, SC0 | 32'h40);
    wrx(ADDR_SC, 32'h0, RESP_OKAY);
    chk(32'(pre_o), 32'h0);
    $display("t_parity done");
  endtask : t_parity
  task automatic end_sim;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // Whole run is well under 2000 register cycles
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    t_reset();
    t_access();
    t_events();
    t_parity();
    end_sim();
  end
endmodule : psi_regs_bench
